// *** rtl/dac_cmd_decoder.sv ***
// two-wire command decoder and register file of the octal converter
// Summary of operation
// [R1] command high nibble, selector low nibble
// [R2] selectors 0-7 channels, 1111 all channels
// [R3] code 0000 loads input register only
// [R4] code 0001 copies input to output
// [R5] code 0010 loads input, updates all outputs
// [R6] code 0011 loads and updates selected channel
// [R7] codes 0100-0111 power, clear, mask, reset
// [R8] codes 1000, 1001 write reference registers
// [R9] read codes 0000/0001 return channel registers
// [R10] read codes return control registers
// [R11] master sends only listed combinations
// [R12] update at falling edge ending lower ack
// [R13] command byte, upper byte, lower byte
// [R14] data 11:4 upper, 3:0 lower top
// [R15] invalid selector high bit: no action; the code still carries out codes 0100-1001 whatever the selector
// [R16] broadcast write address always accepted
// [R17] broadcast address never reads
// [R18] broadcast lets devices update together
// [R19] read: write address, command, restart, read
// [R20] device sends upper then lower byte
// [R21] bare read returns last written register
// [R22] master no-ack: release line, wait
`timescale 1ns/100ps
module dac_cmd_decoder
    import dac_cmd_pkg::*;
#(
    parameter logic [CODE_W-1:0] RESET_CODE = CODE_RESET
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic sclIn,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe,
    input wire logic [2:0] addrPins,
    output logic [CH_COUNT-1:0][CODE_W-1:0] dacCodes,
    output logic [15:0] powerDown,
    output logic [15:0] clearCode,
    output logic [15:0] loadMask,
    output logic [15:0] refCtrl,
    output logic [15:0] refExtra,
    output logic softResetPulse,
    output logic busBusy
);
    // ************************************************************
    // pin synchronisation and bus events
    // ************************************************************
    logic [4:0] pinsSync;
    logic sclS;
    logic sdaS;
    link_state_t s_r;
    link_state_t s_nxt;

    pin_sync #(.WIDTH(5)) u_sync (
        .clock(clock),
        .rst(rst),
        .pins({sclIn, sdaIn, addrPins}),
        .pinsSync(pinsSync)
    );

    assign sclS = pinsSync[4];
    assign sdaS = pinsSync[3];

    // edges and framing conditions seen by the sampled bus
    logic sclRise;
    logic sclFall;
    logic startSeen;
    logic stopSeen;
    assign sclRise = sclS && !s_r.sclPrev;
    assign sclFall = !sclS && s_r.sclPrev;
    assign startSeen = sclS && s_r.sclPrev && s_r.sdaPrev && !sdaS;
    assign stopSeen = sclS && s_r.sclPrev && !s_r.sdaPrev && sdaS;

    // ************************************************************
    // decode of the command and data bytes
    // ************************************************************
    logic [CH_COUNT-1:0][CODE_W-1:0] inCodes;
    logic [15:0] dataWord;
    logic [CH_COUNT-1:0] selMask;
    logic [2:0] selIdx;
    logic addrMatch;
    logic applyUpdate;
    logic loadIn;
    logic [CH_COUNT-1:0] copyMask;
    logic [15:0] txWord;

    assign dataWord = {s_r.upper, s_r.shift};
    assign selIdx = s_r.sel[3] ? 3'h0 : s_r.sel[2:0];
    assign applyUpdate = (s_r.st == ST_RX_ACK) && sclFall && (s_r.byteIdx == BYTE_LOWER); // [R12]

    // own address or broadcast write address
    assign addrMatch = (s_r.shift[7:1] == {ADDR_FIXED, s_r.strap})
        || ((s_r.shift[7:1] == ADDR_BROADCAST) && !s_r.shift[0]); // [R16] [R17]

    // channel selection, broadcast hits all, other high codes hit none
    always_comb begin
        selMask = '0;
        if (s_r.sel == SEL_BROADCAST) begin
            selMask = '1; // [R2] [R18]
        end else if (!s_r.sel[3]) begin
            selMask[s_r.sel[2:0]] = 1'b1; // [R2]
        end
    end

    // channel actions of the data write commands
    always_comb begin
        loadIn = 1'b0;
        copyMask = '0;
        if (applyUpdate) begin
            case (s_r.cmd)
                CMD_WR_INPUT: begin
                    loadIn = 1'b1; // [R3]
                end
                CMD_UPDATE: begin
                    copyMask = selMask; // [R4]
                end
                CMD_WR_LOAD_ALL: begin
                    loadIn = 1'b1;
                    copyMask = (selMask != '0) ? '1 : '0; // [R5] [R15]
                end
                CMD_WR_UPDATE: begin
                    loadIn = 1'b1;
                    copyMask = selMask; // [R6]
                end
                default: begin
                    loadIn = 1'b0; // [R11]
                end
            endcase
        end
    end

    channel_bank #(.RESET_CODE(RESET_CODE)) u_bank (
        .clock(clock),
        .rst(rst),
        .clearAll(s_r.swRst),
        .loadIn(loadIn),
        .loadMask(selMask),
        .value(dataWord[15:4]),
        .copyMask(copyMask),
        .inCodes(inCodes),
        .outCodes(dacCodes)
    );

    // read-back word; the held command also names the last register written
    always_comb begin
        case (s_r.cmd)
            CMD_WR_INPUT, CMD_WR_LOAD_ALL: txWord = {inCodes[selIdx], 4'h0}; // [R9] [R21]
            CMD_UPDATE, CMD_WR_UPDATE: txWord = {dacCodes[selIdx], 4'h0}; // [R9] [R21]
            CMD_POWER: txWord = s_r.ctrl.powerDown; // [R10]
            CMD_CLEAR_CODE: txWord = s_r.ctrl.clearCode; // [R10]
            CMD_LOAD_MASK: txWord = s_r.ctrl.loadMask; // [R10]
            CMD_REF: txWord = s_r.ctrl.refCtrl; // [R10]
            CMD_REF_EXTRA: txWord = s_r.ctrl.refExtra; // [R10]
            default: txWord = 16'h0000;
        endcase
    end

    // ************************************************************
    // bus state machine
    // ************************************************************
    always_comb begin
        s_nxt = s_r;
        s_nxt.sclPrev = sclS;
        s_nxt.sdaPrev = sdaS;
        s_nxt.swRst = 1'b0;
        if (!s_r.strapDone) begin
            s_nxt.strap = pinsSync[2:0];
            s_nxt.strapDone = startSeen; // latch at first start, synchroniser filled by then
        end
        if (startSeen) begin
            s_nxt.st = ST_ADDR;
            s_nxt.bitCnt = 3'h0;
            s_nxt.sdaOe = 1'b0;
        end else if (stopSeen) begin
            s_nxt.st = ST_IDLE;
            s_nxt.sdaOe = 1'b0;
        end else begin
            case (s_r.st)
                ST_ADDR, ST_RX: begin
                    if (sclRise) begin
                        s_nxt.shift = {s_r.shift[6:0], sdaS}; // [R1] [R14]
                        s_nxt.bitCnt = s_r.bitCnt + 3'h1;
                        if (s_r.bitCnt == LAST_BIT) begin
                            s_nxt.st = (s_r.st == ST_ADDR) ? ST_ADDR_CHK : ST_RX_CHK;
                        end
                    end
                end
                ST_ADDR_CHK: begin
                    if (sclFall) begin
                        s_nxt.sdaOe = addrMatch; // [R19]
                        s_nxt.st = addrMatch ? ST_ADDR_ACK : ST_WAIT;
                        s_nxt.byteIdx = BYTE_CA; // [R13]
                        s_nxt.txLow = 1'b0;
                    end
                end
                ST_ADDR_ACK, ST_TX_LOAD: begin
                    if (sclFall) begin
                        s_nxt.bitCnt = 3'h0;
                        if (s_r.st == ST_ADDR_ACK && !s_r.shift[0]) begin
                            s_nxt.sdaOe = 1'b0;
                            s_nxt.st = ST_RX;
                        end else begin
                            s_nxt.shift = s_r.txLow ? txWord[7:0] : txWord[15:8]; // [R20]
                            s_nxt.sdaOe = !s_nxt.shift[7];
                            s_nxt.st = ST_TX;
                        end
                    end
                end
                ST_RX_CHK: begin
                    if (sclFall) begin
                        s_nxt.sdaOe = 1'b1; // [R19]
                        s_nxt.st = ST_RX_ACK;
                        if (s_r.byteIdx == BYTE_CA) begin
                            s_nxt.cmd = s_r.shift[7:4]; // [R1]
                            s_nxt.sel = s_r.shift[3:0]; // [R1]
                        end else if (s_r.byteIdx == BYTE_UPPER) begin
                            s_nxt.upper = s_r.shift; // [R14]
                        end
                    end
                end
                ST_RX_ACK: begin
                    if (sclFall) begin
                        s_nxt.sdaOe = 1'b0;
                        s_nxt.st = ST_RX;
                        s_nxt.byteIdx = (s_r.byteIdx == BYTE_UPPER) ? BYTE_LOWER : BYTE_UPPER; // [R13]
                    end
                    if (applyUpdate) begin
                        case (s_r.cmd)
                            CMD_POWER: s_nxt.ctrl.powerDown = dataWord; // [R7]
                            CMD_CLEAR_CODE: s_nxt.ctrl.clearCode = dataWord; // [R7]
                            CMD_LOAD_MASK: s_nxt.ctrl.loadMask = dataWord; // [R7]
                            CMD_SOFT_RESET: s_nxt.swRst = 1'b1; // [R7]
                            CMD_REF: s_nxt.ctrl.refCtrl = dataWord; // [R8]
                            CMD_REF_EXTRA: s_nxt.ctrl.refExtra = dataWord; // [R8]
                            default: s_nxt.swRst = 1'b0;
                        endcase
                    end
                end
                ST_TX: begin
                    if (sclFall) begin
                        s_nxt.bitCnt = s_r.bitCnt + 3'h1;
                        if (s_r.bitCnt == LAST_BIT) begin
                            s_nxt.sdaOe = 1'b0;
                            s_nxt.st = ST_TX_ACK;
                        end else begin
                            s_nxt.shift = {s_r.shift[6:0], 1'b0};
                            s_nxt.sdaOe = !s_r.shift[6];
                        end
                    end
                end
                ST_TX_ACK: begin
                    if (sclRise) begin
                        s_nxt.st = sdaS ? ST_WAIT : ST_TX_LOAD; // [R22]
                        s_nxt.txLow = !s_r.txLow; // [R20]
                    end
                end
                ST_WAIT: begin
                    s_nxt.sdaOe = 1'b0; // [R22]
                end
                default: begin
                    s_nxt.st = ST_IDLE;
                end
            endcase
        end
        if (s_r.swRst) begin
            s_nxt.ctrl = {5{CTRL_RESET}};
        end
    end

    // power-on state of the link and control registers
    always_ff @(posedge clock) begin
        if (rst) begin
            s_r <= '0;
            s_r.st <= ST_IDLE;
            s_r.sclPrev <= 1'b1;
            s_r.sdaPrev <= 1'b1;
            s_r.ctrl <= {5{CTRL_RESET}};
        end else begin
            s_r <= s_nxt;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    assign sdaOut = 1'b0;
    assign sdaOe = s_r.sdaOe;
    assign powerDown = s_r.ctrl.powerDown;
    assign clearCode = s_r.ctrl.clearCode;
    assign loadMask = s_r.ctrl.loadMask;
    assign refCtrl = s_r.ctrl.refCtrl;
    assign refExtra = s_r.ctrl.refExtra;
    assign softResetPulse = s_r.swRst;
    assign busBusy = (s_r.st != ST_IDLE);

    // ************************************************************
    // checks
    // ************************************************************
    sequence seqApplyCmd(logic [3:0] c);
        applyUpdate && (s_r.cmd == c) && !s_r.sel[3];
    endsequence

    sequence seqNack;
        (s_r.st == ST_TX_ACK) && sclRise && sdaS && !startSeen && !stopSeen;
    endsequence

    chk_input_only: assert property (@(posedge clock) disable iff (rst) // [R3]
        seqApplyCmd(CMD_WR_INPUT) |=> $stable(dacCodes)
            && (inCodes[$past(selIdx)] == $past(dataWord[15:4])))
        else $error("input write changed outputs or missed input");
    chk_update_copy: assert property (@(posedge clock) disable iff (rst) // [R4]
        seqApplyCmd(CMD_UPDATE) |=> dacCodes[$past(selIdx)] == $past(inCodes[selIdx]))
        else $error("update did not copy input register");
    chk_global_load: assert property (@(posedge clock) disable iff (rst) // [R5]
        seqApplyCmd(CMD_WR_LOAD_ALL) |=> dacCodes == inCodes)
        else $error("global load left outputs behind");
    chk_write_update: assert property (@(posedge clock) disable iff (rst) // [R6]
        seqApplyCmd(CMD_WR_UPDATE) |=> dacCodes[$past(selIdx)] == $past(dataWord[15:4]))
        else $error("write and update did not reach output");
    chk_power_write: assert property (@(posedge clock) disable iff (rst) // [R7]
        applyUpdate && s_r.cmd == CMD_POWER |=> powerDown == $past(dataWord))
        else $error("power-down register not written");
    chk_ref_write: assert property (@(posedge clock) disable iff (rst) // [R8]
        applyUpdate && s_r.cmd == CMD_REF_EXTRA |=> refExtra == $past(dataWord))
        else $error("extra reference register not written");
    chk_bad_select: assert property (@(posedge clock) disable iff (rst) // [R15]
        applyUpdate && s_r.sel[3] && s_r.sel != SEL_BROADCAST && s_r.cmd <= CMD_WR_UPDATE
            |=> $stable(inCodes) && $stable(dacCodes))
        else $error("invalid selector caused an action");
    chk_bcast_read: assert property (@(posedge clock) disable iff (rst) // [R17]
        (s_r.st == ST_ADDR_CHK) && sclFall && !startSeen && !stopSeen
            && s_r.shift == {ADDR_BROADCAST, 1'b1} && s_r.strap != 3'h7
            |=> (s_r.st == ST_WAIT) && !sdaOe)
        else $error("broadcast read was acknowledged");
    chk_nack_release: assert property (@(posedge clock) disable iff (rst) // [R22]
        seqNack |=> (s_r.st == ST_WAIT) && !sdaOe)
        else $error("line not released after no-ack");
    chk_soft_reset: assert property (@(posedge clock) disable iff (rst) // [R7]
        applyUpdate && s_r.cmd == CMD_SOFT_RESET |=> softResetPulse
            ##1 (dacCodes == {CH_COUNT{RESET_CODE}}) && powerDown == CTRL_RESET)
        else $error("software reset did not restore registers");
endmodule : dac_cmd_decoder

// *** rtl/dac_cmd_pkg.sv ***
// shared constants, states and carriers of the octal converter command decoder
package dac_cmd_pkg;
    // ************************************************************
    // command codes and selector values
    // ************************************************************
    localparam logic [3:0] CMD_WR_INPUT = 4'h0;
    localparam logic [3:0] CMD_UPDATE = 4'h1;
    localparam logic [3:0] CMD_WR_LOAD_ALL = 4'h2;
    localparam logic [3:0] CMD_WR_UPDATE = 4'h3;
    localparam logic [3:0] CMD_POWER = 4'h4;
    localparam logic [3:0] CMD_CLEAR_CODE = 4'h5;
    localparam logic [3:0] CMD_LOAD_MASK = 4'h6;
    localparam logic [3:0] CMD_SOFT_RESET = 4'h7;
    localparam logic [3:0] CMD_REF = 4'h8;
    localparam logic [3:0] CMD_REF_EXTRA = 4'h9;
    localparam logic [3:0] SEL_BROADCAST = 4'hF;

    // ************************************************************
    // addresses, byte positions and sizes
    // ************************************************************
    localparam logic [3:0] ADDR_FIXED = 4'h9;
    localparam logic [6:0] ADDR_BROADCAST = 7'h47;
    localparam int CH_COUNT = 8;
    localparam int CODE_W = 12;
    localparam logic [1:0] BYTE_CA = 2'h0;
    localparam logic [1:0] BYTE_UPPER = 2'h1;
    localparam logic [1:0] BYTE_LOWER = 2'h2;
    localparam logic [2:0] LAST_BIT = 3'h7;
    localparam logic [15:0] CTRL_RESET = 16'h0000;
    localparam logic [11:0] CODE_RESET = 12'h000;

    // ************************************************************
    // types
    // ************************************************************
    typedef enum logic [3:0] {
        ST_IDLE = 4'h0,
        ST_ADDR = 4'h1,
        ST_ADDR_CHK = 4'h2,
        ST_ADDR_ACK = 4'h3,
        ST_RX = 4'h4,
        ST_RX_CHK = 4'h5,
        ST_RX_ACK = 4'h6,
        ST_TX = 4'h7,
        ST_TX_ACK = 4'h8,
        ST_TX_LOAD = 4'h9,
        ST_WAIT = 4'hA
    } state_t;

    typedef struct packed {
        logic [15:0] powerDown;
        logic [15:0] clearCode;
        logic [15:0] loadMask;
        logic [15:0] refCtrl;
        logic [15:0] refExtra;
    } ctrl_regs_t;

    typedef struct packed {
        state_t st;
        logic [2:0] bitCnt;
        logic [7:0] shift;
        logic [7:0] upper;
        logic [1:0] byteIdx;
        logic [3:0] cmd;
        logic [3:0] sel;
        logic txLow;
        logic sdaOe;
        logic sclPrev;
        logic sdaPrev;
        logic strapDone;
        logic [2:0] strap;
        logic swRst;
        ctrl_regs_t ctrl;
    } link_state_t;

    typedef struct packed {
        logic [CH_COUNT-1:0][CODE_W-1:0] inCodes;
        logic [CH_COUNT-1:0][CODE_W-1:0] outCodes;
    } chan_state_t;
endpackage : dac_cmd_pkg

// *** rtl/pin_sync.sv ***
// two-stage synchroniser for pins from outside the clock domain
`timescale 1ns/100ps
module pin_sync
    import dac_cmd_pkg::*;
#(
    parameter int WIDTH = 5
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic [WIDTH-1:0] pins,
    output logic [WIDTH-1:0] pinsSync
);
    typedef struct packed {
        logic [WIDTH-1:0] stage1;
        logic [WIDTH-1:0] stage2;
    } sync_t;

    sync_t sync_r;
    sync_t sync_nxt;

    // first stage feeds only the second
    always_comb begin
        sync_nxt.stage1 = pins;
        sync_nxt.stage2 = sync_r.stage1;
    end

    // idle bus levels are high
    always_ff @(posedge clock) begin
        if (rst) begin
            sync_r <= '1;
        end else begin
            sync_r <= sync_nxt;
        end
    end

    assign pinsSync = sync_r.stage2;
endmodule : pin_sync

// *** rtl/channel_bank.sv ***
// input holding and output registers of the eight channels
`timescale 1ns/100ps
module channel_bank
    import dac_cmd_pkg::*;
#(
    parameter logic [CODE_W-1:0] RESET_CODE = CODE_RESET
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic clearAll,
    input wire logic loadIn,
    input wire logic [CH_COUNT-1:0] loadMask,
    input wire logic [CODE_W-1:0] value,
    input wire logic [CH_COUNT-1:0] copyMask,
    output logic [CH_COUNT-1:0][CODE_W-1:0] inCodes,
    output logic [CH_COUNT-1:0][CODE_W-1:0] outCodes
);
    chan_state_t bank_r;
    chan_state_t bank_nxt;

    // load inputs; a copy in the same cycle sees the new input value
    always_comb begin
        bank_nxt = bank_r;
        for (int ch = 0; ch < CH_COUNT; ch++) begin
            if (loadIn && loadMask[ch]) begin
                bank_nxt.inCodes[ch] = value;
            end
            if (copyMask[ch]) begin
                bank_nxt.outCodes[ch] = bank_nxt.inCodes[ch];
            end
        end
        if (clearAll) begin
            bank_nxt.inCodes = {CH_COUNT{RESET_CODE}};
            bank_nxt.outCodes = {CH_COUNT{RESET_CODE}};
        end
    end

    // power-on state of all channels
    always_ff @(posedge clock) begin
        if (rst) begin
            bank_r.inCodes <= {CH_COUNT{RESET_CODE}};
            bank_r.outCodes <= {CH_COUNT{RESET_CODE}};
        end else begin
            bank_r <= bank_nxt;
        end
    end

    assign inCodes = bank_r.inCodes;
    assign outCodes = bank_r.outCodes;
endmodule : channel_bank

// *** verification/i2c_master_model.sv ***
// behavioural two-wire bus master that drives the converter link pins
`timescale 1ns/100ps
module i2c_master_model (
    input wire logic clock,
    input wire logic sdaLine,
    output logic scl,
    output logic sdaDrv
);
    // ************************************************************
    // bus conditions and bit transfers, 8 clocks per bit
    // ************************************************************
    initial begin
        scl = 1'b1;
        sdaDrv = 1'b1;
    end
    task q(input int n);
        repeat (n) @(posedge clock);
    endtask : q
    // data set mid low phase, held through the whole high phase
    task bitx(input logic b, output logic r);
        sdaDrv <= b;
        q(2);
        scl <= 1'b1;
        q(3);
        @(negedge clock) r = sdaLine;
        q(1);
        scl <= 1'b0;
        q(2);
    endtask : bitx
    task start();
        sdaDrv <= 1'b0;
        q(4);
        scl <= 1'b0;
        q(2);
    endtask : start
    // repeated start turns a write phase into a read phase
    task restart();
        sdaDrv <= 1'b1;
        q(2);
        scl <= 1'b1;
        q(4);
        start();
    endtask : restart
    task stop();
        sdaDrv <= 1'b0;
        q(2);
        scl <= 1'b1;
        q(4);
        sdaDrv <= 1'b1;
        q(6);
    endtask : stop
    // send a byte msb first, then sample the acknowledge
    task wb(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bitx(d[i], r);
        bitx(1'b1, r);
        ack = ~r;
    endtask : wb
    // receive a byte and acknowledge it or not
    task rb(input logic ackIt, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bitx(1'b1, r);
            d[i] = r;
        end
        bitx(~ackIt, r);
    endtask : rb
endmodule : i2c_master_model

// *** verification/tb_octal_converter_i2c_command_decoder.sv ***
// self-checking bench of the converter command decoder
`timescale 1ns/100ps
module tb_octal_converter_i2c_command_decoder
    import dac_cmd_pkg::*;
;
    // ************************************************************
    // signals, reference model and helpers
    // ************************************************************
    localparam logic [6:0] DEV = {ADDR_FIXED, 3'h5};
    localparam logic [3:0] CMDS [9] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h8, 4'h9};
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic [2:0] addrPins = 3'h5;
    logic scl, sdaDrv, sdaOe, sdaOut, softResetPulse, busBusy, sdaW, k;
    logic [CH_COUNT-1:0][CODE_W-1:0] dacCodes;
    logic [15:0] powerDown, clearCode, loadMask, refCtrl, refExtra;
    int err_count = 0;
    int num_checks = 0;
    int cyc = 0;
    int pulses = 0;
    logic [31:0] seed = 32'hAA75;
    logic [31:0] r;
    logic [11:0] inM [8];
    logic [11:0] outM [8];
    logic [15:0] ctlM [16];
    logic [7:0] lastCa = 8'h00;
    logic [3:0] c;
    always #12.5 clock = ~clock;
    assign sdaW = sdaOe ? (sdaOut & sdaDrv) : sdaDrv; // pulled-up wire
    dac_cmd_decoder DUT (.clock(clock), .rst(rst), .sclIn(scl), .sdaIn(sdaW), .sdaOut(sdaOut),
        .sdaOe(sdaOe), .addrPins(addrPins), .dacCodes(dacCodes), .powerDown(powerDown),
        .clearCode(clearCode), .loadMask(loadMask), .refCtrl(refCtrl), .refExtra(refExtra),
        .softResetPulse(softResetPulse), .busBusy(busBusy));
    i2c_master_model m (.clock(clock), .sdaLine(sdaW), .scl(scl), .sdaDrv(sdaDrv));
    // cycle ceiling and software reset pulse count
    always @(posedge clock) begin
        cyc++;
        if (softResetPulse === 1'b1) pulses++;
        if (cyc == 70000) begin
            err_count++;
            report_and_stop();
        end
    end
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs
    // value a read of the given access byte returns; broadcast reads channel A
    function automatic logic [15:0] expRd(input logic [7:0] ca);
        logic [2:0] s;
        s = (ca[3:0] == SEL_BROADCAST) ? 3'h0 : ca[2:0];
        case (ca[7:4])
            4'h0, 4'h2: return {inM[s], 4'h0};
            4'h1, 4'h3: return {outM[s], 4'h0};
            default: return ctlM[ca[7:4]];
        endcase
    endfunction : expRd
    // reference update for one accepted write word
    task model(input logic [7:0] ca, input logic [15:0] w);
        logic v;
        v = !ca[3] || ca[3:0] == SEL_BROADCAST;
        for (int i = 0; i < 8; i++) begin
            if (v && (ca[3:0] == SEL_BROADCAST || ca[3:0] == i)) begin
                if (ca[7:4] inside {4'h0, 4'h2, 4'h3}) inM[i] = w[15:4];
                if (ca[7:4] inside {4'h1, 4'h3}) outM[i] = inM[i];
            end
        end
        for (int i = 0; i < 8; i++) begin
            if (v && ca[7:4] == 4'h2) outM[i] = inM[i];
            if (ca[7:4] == 4'h7) {inM[i], outM[i]} = '0;
        end
        if (ca[7:4] inside {4'h4, 4'h5, 4'h6, 4'h8, 4'h9}) ctlM[ca[7:4]] = w;
        if (ca[7:4] == 4'h7) ctlM = '{default: 16'h0000};
        lastCa = ca;
    endtask : model
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task chkOut(input logic busy);
        for (int i = 0; i < 8; i++) chk(32'(dacCodes[i]), 32'(outM[i]));
        chk({powerDown, clearCode}, {ctlM[4], ctlM[5]});
        chk({loadMask, refCtrl}, {ctlM[6], ctlM[8]});
        chk({refExtra, 15'h0, busBusy}, {ctlM[9], 15'h0, busy});
    endtask : chkOut
    task wr(input logic [6:0] a, input logic [7:0] ca, input logic [15:0] w, input logic ak);
        m.start();
        m.wb({a, 1'b0}, k);
        chk({k, busBusy}, {ak, 1'b1});
        if (ak) begin
            m.wb(ca, k);
            m.wb(w[15:8], k);
            chkOut(1'b1);
            m.wb(w[7:0], k);
            model(ca, w);
        end
        m.stop();
        m.q(4);
        chkOut(1'b0);
    endtask : wr
    task rd(input logic [7:0] ca, input logic bare, input logic nk);
        logic [7:0] hi, lo;
        m.start();
        if (!bare) begin
            m.wb({DEV, 1'b0}, k);
            m.wb(ca, k);
            m.restart();
            lastCa = ca;
        end
        m.wb({DEV, 1'b1}, k);
        chk(32'(k), 32'h1);
        m.rb(!nk, hi);
        if (nk) begin
            m.q(8);
            chk(32'(sdaOe), 32'h0);
        end else begin
            m.rb(1'b0, lo);
            chk({hi, lo}, expRd(lastCa));
        end
        m.stop();
    endtask : rd
    task report_and_stop();
        $display("checks=%0d errors=%0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : report_and_stop
    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        inM = '{default: 12'h000};
        outM = '{default: 12'h000};
        ctlM = '{default: 16'h0000};
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        m.q(6);
        chkOut(1'b0);
        // every listed command first, then random ones, each read back
        for (int j = 0; j < 30; j++) begin
            r = xs();
            c = CMDS[j < 9 ? j : r[3:0] % 9];
            wr(DEV, {c, r[4] ? SEL_BROADCAST : {1'b0, r[7:5]}}, r[31:16], 1'b1);
            rd({c, r[4] ? SEL_BROADCAST : {1'b0, r[7:5]}}, r[8], 1'b0);
        end
        wr(DEV, 8'h0A, 16'hFFF0, 1'b1);
        wr(DEV, 8'h3C, 16'h1230, 1'b1);
        addrPins <= 3'h2;
        wr(ADDR_BROADCAST, 8'h3F, 16'h5A5F, 1'b1);
        m.start();
        m.wb({ADDR_BROADCAST, 1'b1}, k);
        m.stop();
        chk(32'(k), 32'h0);
        wr({ADDR_FIXED, 3'h2}, 8'h30, 16'h1230, 1'b0);
        rd(8'h17, 1'b0, 1'b1);
        rd(8'h17, 1'b0, 1'b0);
        pulses = 0;
        wr(DEV, 8'h70, 16'h0000, 1'b1);
        chk(pulses, 1);
        wr(DEV, 8'h31, 16'hABC0, 1'b1);
        rd(8'h00, 1'b1, 1'b0);
        report_and_stop();
    end
endmodule : tb_octal_converter_i2c_command_decoder
